/* src/alu_pkg.sv */
// constants, opcodes and condition codes for the saturating simd pack datapath
`default_nettype none

package alu_pkg;

    // operand and field widths
    localparam int DATA_W    = 32;
    localparam int HALF_W    = 16;
    localparam int BYTE_W    = 8;
    localparam int SHIFT_W   = 5;
    localparam int ROT_W     = 2;
    localparam int COND_W    = 4;
    localparam int FLAG_W    = 4;
    localparam int REG_IDX_W = 4;
    localparam int NUM_BYTES = 4;
    localparam int NUM_HALFS = 2;

    // saturation limits
    localparam logic [31:0] SAT_MAX  = 32'h7fffffff;
    localparam logic [31:0] SAT_MIN  = 32'h80000000;
    localparam logic [15:0] HALF_MAX = 16'hffff;
    localparam logic [15:0] HALF_MIN = 16'h0000;
    localparam logic [7:0]  BYTE_MAX = 8'hff;
    localparam logic [7:0]  BYTE_MIN = 8'h00;

    // a zero shift field on the top-bottom pack stands for a full-width shift
    localparam logic [5:0]  ASR_FULL = 6'h20;

    // positions of the condition flags in the flag word
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;

    // condition codes
    localparam logic [3:0] COND_EQ = 4'h0;
    localparam logic [3:0] COND_NE = 4'h1;
    localparam logic [3:0] COND_CS = 4'h2;
    localparam logic [3:0] COND_CC = 4'h3;
    localparam logic [3:0] COND_MI = 4'h4;
    localparam logic [3:0] COND_PL = 4'h5;
    localparam logic [3:0] COND_VS = 4'h6;
    localparam logic [3:0] COND_VC = 4'h7;
    localparam logic [3:0] COND_HI = 4'h8;
    localparam logic [3:0] COND_LS = 4'h9;
    localparam logic [3:0] COND_GE = 4'ha;
    localparam logic [3:0] COND_LT = 4'hb;
    localparam logic [3:0] COND_GT = 4'hc;
    localparam logic [3:0] COND_LE = 4'hd;

    // reset values
    localparam logic [31:0] RESULT_RST = 32'h00000000;
    localparam logic [3:0]  IDX_RST    = 4'h0;
    localparam logic [3:0]  FLAGS_RST  = 4'h0;

    typedef enum logic [13:0] {
        OP_SIGNED_DOUBLE_ADD_SAT         = 14'h0001,
        OP_SIGNED_DOUBLE_SUB_SAT         = 14'h0002,
        OP_UNSIGNED_ADD_SUB_EXCHANGE_SAT = 14'h0004,
        OP_UNSIGNED_SUB_ADD_EXCHANGE_SAT = 14'h0008,
        OP_UNSIGNED_QUAD_BYTE_ADD_SAT    = 14'h0010,
        OP_UNSIGNED_DUAL_HALF_ADD_SAT    = 14'h0020,
        OP_UNSIGNED_QUAD_BYTE_SUB_SAT    = 14'h0040,
        OP_UNSIGNED_DUAL_HALF_SUB_SAT    = 14'h0080,
        OP_PACK_BOTTOM_TOP_LSL           = 14'h0100,
        OP_PACK_TOP_BOTTOM_ASR           = 14'h0200,
        OP_SIGN_EXTEND_BYTE_ADD          = 14'h0400,
        OP_ZERO_EXTEND_BYTE_ADD          = 14'h0800,
        OP_DUAL_SIGN_EXTEND_BYTE         = 14'h1000,
        OP_DUAL_ZERO_EXTEND_BYTE         = 14'h2000
    } alu_op_e;

endpackage

`default_nettype wire

/* src/cond_eval.sv */
// condition code evaluator against the current condition flags
`default_nettype none

module cond_eval (
    cond_if.evaluator cif
);

    logic n_flag;
    logic z_flag;
    logic c_flag;
    logic v_flag;

    assign n_flag = cif.flags[alu_pkg::FLAG_N];
    assign z_flag = cif.flags[alu_pkg::FLAG_Z];
    assign c_flag = cif.flags[alu_pkg::FLAG_C];
    assign v_flag = cif.flags[alu_pkg::FLAG_V];

    always_comb
    begin
        unique case (cif.cond)
            alu_pkg::COND_EQ: cif.pass = z_flag;
            alu_pkg::COND_NE: cif.pass = !z_flag;
            alu_pkg::COND_CS: cif.pass = c_flag;
            alu_pkg::COND_CC: cif.pass = !c_flag;
            alu_pkg::COND_MI: cif.pass = n_flag;
            alu_pkg::COND_PL: cif.pass = !n_flag;
            alu_pkg::COND_VS: cif.pass = v_flag;
            alu_pkg::COND_VC: cif.pass = !v_flag;
            alu_pkg::COND_HI: cif.pass = c_flag && !z_flag;
            alu_pkg::COND_LS: cif.pass = !c_flag || z_flag;
            alu_pkg::COND_GE: cif.pass = (n_flag == v_flag);
            alu_pkg::COND_LT: cif.pass = (n_flag != v_flag);
            alu_pkg::COND_GT: cif.pass = !z_flag && (n_flag == v_flag);
            alu_pkg::COND_LE: cif.pass = z_flag || (n_flag != v_flag);
            // always, and the unused code treated as always
            default:          cif.pass = 1'b1;
        endcase
    end

endmodule

`default_nettype wire

/* src/cond_if.sv */
// condition check request and answer between the datapath and its evaluator
`default_nettype none

interface cond_if;
    logic [3:0] cond;
    logic [3:0] flags;
    logic       pass;

    modport evaluator (input cond, input flags, output pass);
    modport requester (output cond, output flags, input pass);
endinterface

`default_nettype wire

/* src/saturating_simd_pack_alu.sv */
// saturating doubling, unsigned simd saturating, pack and extend datapath with one result stage
`default_nettype none

// Summary of operation
// RQ1: doubling add: double and clamp second operand, add first, clamp, write result.
// RQ2: doubling subtract: double and clamp second, subtract from first, clamp, write.
// RQ3: both doubling steps clamp to the signed 32-bit range.
// RQ4: any clamp in a doubling step sets the sticky saturation flag, else unchanged.
// RQ5: add-sub-exchange: first bottom plus second top, clamped unsigned, into top half.
// RQ6: add-sub-exchange: difference with second bottom, clamped unsigned, into bottom half.
// RQ7: sub-add-exchange: first top minus second bottom, clamped unsigned, into top half.
// RQ8: sub-add-exchange: first bottom plus second top, clamped unsigned, into bottom half.
// RQ9: dual halfword add: each half sum clamped to zero through 65535.
// RQ10: quad byte add: each byte sum clamped to zero through 255.
// RQ11: dual halfword subtract: each difference clamped, negative becomes zero.
// RQ12: quad byte subtract: each byte difference clamped to the unsigned byte range.
// RQ13: unsigned exchange and parallel operations leave condition flags unmodified.
// RQ14: software never names stack pointer or program counter for these operations.
// RQ15: an operation executes only when its condition code passes on current flags.
// RQ16: bottom-top pack shifts second operand left by 1 to 31, zero is none.
// RQ17: top-bottom pack shifts right arithmetic 1 to 32, zero field means 32.
// RQ18: bottom-top pack: first bottom half low, shifted second top half high.
// RQ19: top-bottom pack: first top half high, shifted second bottom half low.
// RQ20: extend operations rotate the source right by 0, 8, 16 or 24 first.
// RQ21: byte extend takes bits 7..0, dual forms also 23..16 to halfwords.
// RQ22: parallel lanes saturate independently, no carry or borrow between lanes.
module saturating_simd_pack_alu (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // issue from the decoder and register file
    input  wire logic              issue_valid_i,
    input  wire alu_pkg::alu_op_e  op_i,
    input  wire logic [3:0]        cond_i,
    input  wire logic [3:0]        flags_i,
    input  wire logic [3:0]        dest_i,
    input  wire logic [31:0]       op_a_i,
    input  wire logic [31:0]       op_b_i,
    input  wire logic [4:0]        shift_i,
    input  wire logic [1:0]        rotate_i,
    // status word control
    input  wire logic              sat_clear_i,
    // result to the register file
    output logic [31:0]            result_o,
    output logic                   result_we_o,
    output logic [3:0]             dest_o,
    output logic [3:0]             flags_o,
    output logic                   sat_flag_o,
    output logic                   illegal_op_o
);

    cond_if cif ();

    logic        cond_pass;

    logic [31:0] dbl_val;
    logic        dbl_ovf;
    logic [32:0] dbl_sum;
    logic [32:0] dbl_diff;
    logic [31:0] dadd_val;
    logic [31:0] dsub_val;
    logic        dadd_ovf;
    logic        dsub_ovf;

    logic [31:0] asx_val;
    logic [31:0] sax_val;
    logic [31:0] qb_add_val;
    logic [31:0] qb_sub_val;
    logic [31:0] dh_add_val;
    logic [31:0] dh_sub_val;

    logic [31:0] lsl_val;
    logic [5:0]  asr_amt;
    logic [31:0] asr_val;
    logic [31:0] rot_val;

    logic [31:0] result_next;
    logic        sat_set_next;
    logic        legal_next;
    logic        exec_next;

    logic [31:0] result_reg;
    logic        result_we_reg;
    logic [3:0]  dest_reg;
    logic [3:0]  flags_reg;
    logic        sat_flag_reg;
    logic        illegal_reg;

    // unsigned 16-bit add clamped at the top
    function automatic logic [15:0] uadd16(input logic [15:0] x, input logic [15:0] y);
        logic [16:0] s;
        s = {1'b0, x} + {1'b0, y};
        return s[16] ? alu_pkg::HALF_MAX : s[15:0];
    endfunction

    // unsigned 16-bit subtract clamped at zero
    function automatic logic [15:0] usub16(input logic [15:0] x, input logic [15:0] y);
        logic [16:0] d;
        d = {1'b0, x} - {1'b0, y};
        return d[16] ? alu_pkg::HALF_MIN : d[15:0];
    endfunction

    // signed 33-bit value clamped into 32 bits
    function automatic logic [31:0] sat_s32(input logic [32:0] x);
        logic ovf;
        ovf = x[32] ^ x[31];
        return ovf ? (x[32] ? alu_pkg::SAT_MIN : alu_pkg::SAT_MAX) : x[31:0];
    endfunction

    assign cif.cond  = cond_i;
    assign cif.flags = flags_i;
    assign cond_pass = cif.pass;

    cond_eval u_cond_eval (
        .cif (cif.evaluator)
    );

    // shared execute term
    assign exec_next = issue_valid_i && cond_pass && legal_next;  // [RQ15]

    // doubling: overflow exactly when the two top bits of the operand differ
    assign dbl_ovf = op_b_i[31] ^ op_b_i[30];                                                 // [RQ3]
    assign dbl_val = dbl_ovf ? (op_b_i[31] ? alu_pkg::SAT_MIN : alu_pkg::SAT_MAX)
                             : {op_b_i[30:0], 1'b0};                                          // [RQ1] [RQ2]
    assign dbl_sum  = {op_a_i[31], op_a_i} + {dbl_val[31], dbl_val};                          // [RQ1]
    assign dbl_diff = {op_a_i[31], op_a_i} - {dbl_val[31], dbl_val};                          // [RQ2]
    assign dadd_val = sat_s32(dbl_sum);                                                       // [RQ3]
    assign dsub_val = sat_s32(dbl_diff);                                                      // [RQ3]
    assign dadd_ovf = dbl_ovf || (dbl_sum[32] ^ dbl_sum[31]);                                 // [RQ4]
    assign dsub_ovf = dbl_ovf || (dbl_diff[32] ^ dbl_diff[31]);                               // [RQ4]

    // exchange forms cross the halves of the second operand
    assign asx_val = {uadd16(op_a_i[15:0], op_b_i[31:16]),                                    // [RQ5]
                      usub16(op_a_i[31:16], op_b_i[15:0])};                                   // [RQ6]
    assign sax_val = {usub16(op_a_i[31:16], op_b_i[15:0]),                                    // [RQ7]
                      uadd16(op_a_i[15:0], op_b_i[31:16])};                                   // [RQ8]

    // each lane has its own carry bit, so nothing ripples into the neighbour
    for (genvar g = 0; g < alu_pkg::NUM_BYTES; g++)
    begin : g_byte
        logic [8:0] bsum;
        logic [8:0] bdiff;
        assign bsum  = {1'b0, op_a_i[g*8 +: 8]} + {1'b0, op_b_i[g*8 +: 8]};                  // [RQ22]
        assign bdiff = {1'b0, op_a_i[g*8 +: 8]} - {1'b0, op_b_i[g*8 +: 8]};                  // [RQ22]
        assign qb_add_val[g*8 +: 8] = bsum[8] ? alu_pkg::BYTE_MAX : bsum[7:0];               // [RQ10]
        assign qb_sub_val[g*8 +: 8] = bdiff[8] ? alu_pkg::BYTE_MIN : bdiff[7:0];             // [RQ12]
    end

    for (genvar h = 0; h < alu_pkg::NUM_HALFS; h++)
    begin : g_half
        assign dh_add_val[h*16 +: 16] = uadd16(op_a_i[h*16 +: 16], op_b_i[h*16 +: 16]);     // [RQ9] [RQ22]
        assign dh_sub_val[h*16 +: 16] = usub16(op_a_i[h*16 +: 16], op_b_i[h*16 +: 16]);     // [RQ11] [RQ22]
    end

    // pack shifts; a zero field is a plain copy for lsl but a full sign fill for asr
    assign lsl_val = op_b_i << shift_i;                                                       // [RQ16]
    assign asr_amt = (shift_i == 5'h00) ? alu_pkg::ASR_FULL : {1'b0, shift_i};                // [RQ17]
    assign asr_val = 32'($signed(op_b_i) >>> asr_amt);                                        // [RQ17]

    always_comb
    begin
        unique case (rotate_i)                                                                // [RQ20]
            2'h0: rot_val = op_b_i;
            2'h1: rot_val = {op_b_i[7:0], op_b_i[31:8]};
            2'h2: rot_val = {op_b_i[15:0], op_b_i[31:16]};
            2'h3: rot_val = {op_b_i[23:0], op_b_i[31:24]};
        endcase
    end

    always_comb
    begin
        result_next  = alu_pkg::RESULT_RST;
        sat_set_next = 1'b0;
        legal_next   = 1'b1;
        unique case (op_i)
            alu_pkg::OP_SIGNED_DOUBLE_ADD_SAT:
            begin
                result_next  = dadd_val;                                                      // [RQ1]
                sat_set_next = dadd_ovf;                                                      // [RQ4]
            end
            alu_pkg::OP_SIGNED_DOUBLE_SUB_SAT:
            begin
                result_next  = dsub_val;                                                      // [RQ2]
                sat_set_next = dsub_ovf;                                                      // [RQ4]
            end
            alu_pkg::OP_UNSIGNED_ADD_SUB_EXCHANGE_SAT: result_next = asx_val;                 // [RQ5] [RQ6]
            alu_pkg::OP_UNSIGNED_SUB_ADD_EXCHANGE_SAT: result_next = sax_val;                 // [RQ7] [RQ8]
            alu_pkg::OP_UNSIGNED_QUAD_BYTE_ADD_SAT:    result_next = qb_add_val;              // [RQ10]
            alu_pkg::OP_UNSIGNED_DUAL_HALF_ADD_SAT:    result_next = dh_add_val;              // [RQ9]
            alu_pkg::OP_UNSIGNED_QUAD_BYTE_SUB_SAT:    result_next = qb_sub_val;              // [RQ12]
            alu_pkg::OP_UNSIGNED_DUAL_HALF_SUB_SAT:    result_next = dh_sub_val;              // [RQ11]
            alu_pkg::OP_PACK_BOTTOM_TOP_LSL:
                result_next = {lsl_val[31:16], op_a_i[15:0]};                                 // [RQ18]
            alu_pkg::OP_PACK_TOP_BOTTOM_ASR:
                result_next = {op_a_i[31:16], asr_val[15:0]};                                 // [RQ19]
            alu_pkg::OP_SIGN_EXTEND_BYTE_ADD:
                result_next = op_a_i + {{24{rot_val[7]}}, rot_val[7:0]};                      // [RQ21]
            alu_pkg::OP_ZERO_EXTEND_BYTE_ADD:
                result_next = op_a_i + {24'h000000, rot_val[7:0]};                            // [RQ21]
            alu_pkg::OP_DUAL_SIGN_EXTEND_BYTE:
                result_next = {{8{rot_val[23]}}, rot_val[23:16], {8{rot_val[7]}}, rot_val[7:0]}; // [RQ21]
            alu_pkg::OP_DUAL_ZERO_EXTEND_BYTE:
                result_next = {8'h00, rot_val[23:16], 8'h00, rot_val[7:0]};                   // [RQ21]
            default: legal_next = 1'b0;
        endcase
    end

    // result stage; a failed condition leaves the destination untouched
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            result_reg    <= alu_pkg::RESULT_RST;
            result_we_reg <= 1'b0;
            dest_reg      <= alu_pkg::IDX_RST;
        end
        else
        begin
            result_we_reg <= exec_next;                                                        // [RQ15]
            if (exec_next)
            begin
                result_reg <= result_next;
                dest_reg   <= dest_i;
            end
        end
    end

    // none of these operations write n, z, c or v; the flags go back as received
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            flags_reg <= alu_pkg::FLAGS_RST;
        else if (issue_valid_i)
            flags_reg <= flags_i;                                                             // [RQ13]
    end

    // sticky flag: a set in the same cycle as a clear wins
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            sat_flag_reg <= 1'b0;
        else if (exec_next && sat_set_next)
            sat_flag_reg <= 1'b1;                                                             // [RQ4]
        else if (sat_clear_i)
            sat_flag_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            illegal_reg <= 1'b0;
        else
            illegal_reg <= issue_valid_i && !legal_next;
    end

    assign result_o     = result_reg;
    assign result_we_o  = result_we_reg;
    assign dest_o       = dest_reg;
    assign flags_o      = flags_reg;
    assign sat_flag_o   = sat_flag_reg;
    assign illegal_op_o = illegal_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence issue_s(alu_pkg::alu_op_e opc);
        issue_valid_i && cond_pass && (op_i == opc);
    endsequence

    sequence dbl_pos_ovf_s;
        op_b_i[31:30] == 2'b01;
    endsequence

    dbl_add_clamp_a: assert property (issue_s(alu_pkg::OP_SIGNED_DOUBLE_ADD_SAT) and dbl_pos_ovf_s // [RQ1]
        and !op_a_i[31] |=> result_o == 32'h7fffffff && sat_flag_o && result_we_o)
        else $error("doubling add did not clamp to the positive limit");

    dbl_sub_clamp_a: assert property (issue_s(alu_pkg::OP_SIGNED_DOUBLE_SUB_SAT) and dbl_pos_ovf_s // [RQ2]
        and op_a_i[31] |=> result_o == 32'h80000000 && sat_flag_o)
        else $error("doubling subtract did not clamp to the negative limit");

    dbl_neg_range_a: assert property (issue_s(alu_pkg::OP_SIGNED_DOUBLE_ADD_SAT) // [RQ3]
        and op_b_i == 32'h80000000 and op_a_i == 32'h00000000 |=> result_o == 32'h80000000)
        else $error("doubled operand was not held at the negative limit");

    dbl_zero_pass_a: assert property (issue_s(alu_pkg::OP_SIGNED_DOUBLE_ADD_SAT) // [RQ1]
        and op_b_i == 32'h00000000 |=> result_o == $past(op_a_i))
        else $error("doubling add of zero changed the first operand");

    sat_sticky_a: assert property (!sat_flag_o && !(issue_valid_i && cond_pass && sat_set_next) // [RQ4]
        |=> !sat_flag_o)
        else $error("saturation flag set without a saturating doubling step");

    sat_hold_a: assert property (sat_flag_o && !sat_clear_i |=> sat_flag_o [*1]) // [RQ4]
        else $error("saturation flag dropped without a clear");

    asx_lanes_a: assert property (issue_s(alu_pkg::OP_UNSIGNED_ADD_SUB_EXCHANGE_SAT) // [RQ5]
        and op_a_i[15:0] == 16'hffff and op_b_i[31:16] != 16'h0000
        and op_a_i[31:16] < op_b_i[15:0] |=> result_o == 32'hffff0000)
        else $error("add-sub-exchange lanes not clamped");

    sax_lanes_a: assert property (issue_s(alu_pkg::OP_UNSIGNED_SUB_ADD_EXCHANGE_SAT) // [RQ7]
        and op_a_i[15:0] == 16'hffff and op_b_i[31:16] != 16'h0000
        and op_a_i[31:16] < op_b_i[15:0] |=> result_o == 32'h0000ffff)
        else $error("sub-add-exchange lanes not clamped");

    byte_sub_zero_a: assert property (issue_s(alu_pkg::OP_UNSIGNED_QUAD_BYTE_SUB_SAT) // [RQ12]
        and op_a_i == 32'h00000000 |=> result_o == 32'h00000000)
        else $error("byte subtract below zero not clamped to zero");

    byte_add_full_a: assert property (issue_s(alu_pkg::OP_UNSIGNED_QUAD_BYTE_ADD_SAT) // [RQ10]
        and op_a_i == 32'hff00ff00 and op_b_i == 32'h01010101 |=> result_o == 32'hff01ff01)
        else $error("byte add carried between lanes or failed to clamp");

    half_add_a: assert property (issue_s(alu_pkg::OP_UNSIGNED_DUAL_HALF_ADD_SAT) // [RQ9]
        and op_a_i == 32'h0000ffff and op_b_i == 32'h00010001 |=> result_o == 32'h0001ffff)
        else $error("halfword add carried between lanes or failed to clamp");

    pack_bt_a: assert property (issue_s(alu_pkg::OP_PACK_BOTTOM_TOP_LSL) and shift_i == 5'h00 // [RQ16]
        |=> result_o == {$past(op_b_i[31:16]), $past(op_a_i[15:0])})
        else $error("bottom-top pack with zero shift is wrong");

    pack_tb_a: assert property (issue_s(alu_pkg::OP_PACK_TOP_BOTTOM_ASR) and shift_i == 5'h00 // [RQ17]
        |=> result_o[15:0] == {16{$past(op_b_i[31])}} && result_o[31:16] == $past(op_a_i[31:16]))
        else $error("top-bottom pack zero field is not a full shift");

    cond_fail_a: assert property (issue_valid_i && !cond_pass |=> !result_we_o // [RQ15]
        ##0 $stable(result_o))
        else $error("result written although the condition failed");

    flags_kept_a: assert property (issue_valid_i |=> flags_o == $past(flags_i)) // [RQ13]
        else $error("condition flags altered");

    illegal_op_a: assert property (issue_valid_i && !legal_next |=> illegal_op_o && !result_we_o) // [RQ15]
        else $error("illegal opcode executed");

    idle_write_a: assert property (!issue_valid_i |=> !result_we_o) // [RQ15]
        else $error("write without an issue");

endmodule

`default_nettype wire

/* test/regfile_model.sv */
// register file model that takes the results written back by the datapath
`default_nettype none
module regfile_model (
    // write port from the datapath
    input  wire logic        clk_sys_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  dest_i,
    input  wire logic [31:0] data_i,
    // read port for the bench
    input  wire logic [3:0]  rd_idx_i,
    output logic [31:0]      rd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // only general registers are ever named, never stack pointer or program counter
    logic [31:0] regs [16];
    always @(posedge clk_sys_i)
        if (we_i)
            regs[dest_i] <= data_i;
    assign rd_data_o = regs[rd_idx_i];
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the saturating simd pack datapath
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk_sys_i = '0, rst_i = '1, issue_valid_i = '0, sat_clear_i = '0, exp_sat = '0;
    alu_pkg::alu_op_e op_i = alu_pkg::OP_SIGNED_DOUBLE_ADD_SAT;
    logic [3:0]       cond_i = '0, flags_i = '0, dest_i = '0, exp_dest = '0, dest_o, flags_o;
    logic [31:0]      op_a_i = '0, op_b_i = '0, exp_res = '0, result_o, rd_data;
    logic [4:0]       shift_i = '0;
    logic [1:0]       rotate_i = '0;
    logic             result_we_o, sat_flag_o, illegal_op_o;
    int               errors = 0, checks = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    saturating_simd_pack_alu DUT (.clk_sys_i, .rst_i, .issue_valid_i, .op_i, .cond_i, .flags_i, .dest_i, .op_a_i,
        .op_b_i, .shift_i, .rotate_i, .sat_clear_i, .result_o, .result_we_o, .dest_o, .flags_o, .sat_flag_o,
        .illegal_op_o);
    regfile_model rf (.clk_sys_i, .we_i(result_we_o), .dest_i(dest_o), .data_i(result_o), .rd_idx_i(exp_dest),
        .rd_data_o(rd_data));
    // unsigned clamp: negative differences floor at zero, sums cap at mx
    function automatic logic [15:0] us(logic [15:0] x, y, logic sub, logic [15:0] mx);
        logic [16:0] t = sub ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
        return t[16] ? (sub ? 16'h0000 : mx) : (t[15:0] > mx ? mx : t[15:0]);
    endfunction
    function automatic logic cpass(logic [3:0] c, logic [3:0] f);
        logic [7:0] t = {1'b1, ~f[2] & (f[3] == f[0]), f[3] == f[0], f[1] & ~f[2], f[0], f[3], f[1], f[2]};
        return c[3:1] == 3'h7 ? 1'b1 : t[c[3:1]] ^ c[0];
    endfunction
    // returns this operation's saturation bit above the 32-bit result
    function automatic logic [32:0] model(logic [13:0] op, logic [31:0] a, b, logic [4:0] sh, logic [1:0] ro);
        logic [31:0] r = 32'({b, b} >> (8 * ro)), l = b << sh, bq, d;
        logic signed [31:0] bs = $signed(b) >>> ((sh == 5'h00) ? 6'h20 : {1'b0, sh});
        logic [32:0] s;
        logic [15:0] t;
        logic q = b[31] != b[30], u = op == 14'h0040 || op == 14'h0080;
        d = q ? (b[31] ? 32'h80000000 : 32'h7fffffff) : b << 1;
        s = op == 14'h0002 ? {a[31], a} - {d[31], d} : {a[31], a} + {d[31], d};
        if (s[32] != s[31]) {q, s[31:0]} = {1'b1, s[32] ? 32'h80000000 : 32'h7fffffff};
        for (int i = 0; i < 4; i++)
        begin
            t = us({8'h00, a[8*i +: 8]}, {8'h00, b[8*i +: 8]}, u, 16'h00ff);
            bq[8*i +: 8] = t[7:0];
        end
        case (op)
            14'h0001, 14'h0002: return {q, s[31:0]};
            14'h0004: return {1'b0, us(a[15:0], b[31:16], 0, 16'hffff), us(a[31:16], b[15:0], 1, 16'hffff)};
            14'h0008: return {1'b0, us(a[31:16], b[15:0], 1, 16'hffff), us(a[15:0], b[31:16], 0, 16'hffff)};
            14'h0010, 14'h0040: return {1'b0, bq};
            14'h0020, 14'h0080: return {1'b0, us(a[31:16], b[31:16], u, 16'hffff), us(a[15:0], b[15:0], u, 16'hffff)};
            14'h0100: return {1'b0, l[31:16], a[15:0]};
            14'h0200: return {1'b0, a[31:16], bs[15:0]};
            14'h0400: return {1'b0, a + {{24{r[7]}}, r[7:0]}};
            14'h0800: return {1'b0, a + {24'h000000, r[7:0]}};
            14'h1000: return {1'b0, {8{r[23]}}, r[23:16], {8{r[7]}}, r[7:0]};
            default: return {1'b0, 8'h00, r[23:16], 8'h00, r[7:0]};
        endcase
    endfunction
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(logic [13:0] op, logic [31:0] a, b, logic [4:0] sh, logic [1:0] ro, logic [3:0] c, f,
        logic clr);
        logic [32:0] e = model(op, a, b, sh, ro);
        logic        bad = $countones(op) != 1;
        logic        go = cpass(c, f) && !bad;
        logic [3:0]  d = 4'($urandom_range(12, 0));
        @(posedge clk_sys_i);
        {issue_valid_i, sat_clear_i, cond_i, flags_i, dest_i} <= {1'b1, clr, c, f, d};
        {op_a_i, op_b_i, shift_i, rotate_i} <= {a, b, sh, ro};
        op_i <= alu_pkg::alu_op_e'(op);
        @(posedge clk_sys_i);
        {issue_valid_i, sat_clear_i} <= 2'h0;
        #1;
        if (go) {exp_res, exp_dest} = {e[31:0], d};
        exp_sat = (go && e[32]) || (exp_sat && !clr);
        chk("write enable", 32'(go), 32'(result_we_o));
        chk("illegal", 32'(bad), 32'(illegal_op_o));
        chk("result", exp_res, result_o);
        chk("dest", 32'(exp_dest), 32'(dest_o));
        chk("flags", 32'(f), 32'(flags_o));
        chk("sticky", 32'(exp_sat), 32'(sat_flag_o));
        @(posedge clk_sys_i);
        #1;
        chk("register file", exp_res, rd_data);
    endtask
    task automatic corner(logic [13:0] op, logic [31:0] a, b);
        run(op, a, b, 5'h0, 2'h0, 4'he, 4'h0, 1'b0);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (8000) @(posedge clk_sys_i);
        errors++;
        close_out();
    end
    initial
    begin
        void'($urandom(41852));
        repeat (6) @(posedge clk_sys_i);
        chk("reset write enable", 32'h0, 32'(result_we_o));
        rst_i <= 1'b0;
        run(14'h0001, 32'h0, 32'h40000000, 5'h00, 2'h0, 4'he, 4'h0, 1'b0);
        run(14'h0002, 32'h80000000, 32'h1, 5'h00, 2'h0, 4'he, 4'h0, 1'b1);
        run(14'h0010, 32'hff0180ff, 32'h01ff80ff, 5'h00, 2'h0, 4'he, 4'h0, 1'b1);
        run(14'h0040, 32'h00ff0180, 32'h01000280, 5'h00, 2'h0, 4'he, 4'h0, 1'b0);
        run(14'h0200, 32'h1234abcd, 32'h80000000, 5'h00, 2'h0, 4'he, 4'h0, 1'b0);
        run(14'h0100, 32'h1234abcd, 32'h00000003, 5'h1f, 2'h0, 4'he, 4'h0, 1'b0);
        run(14'h0003, 32'h1, 32'h1, 5'h00, 2'h0, 4'he, 4'h0, 1'b0);
        run(14'h0001, 32'h7fffffff, 32'h1, 5'h00, 2'h0, 4'h0, 4'h0, 1'b0);
        corner(14'h0001, 32'h0, 32'h80000000);
        corner(14'h0001, 32'h12345678, 32'h0);
        corner(14'h0002, 32'h80000005, 32'h40000000);
        corner(14'h0004, 32'h0001ffff, 32'h00020002);
        corner(14'h0008, 32'h0001ffff, 32'h00020002);
        corner(14'h0040, 32'h0, 32'h01020304);
        corner(14'h0010, 32'hff00ff00, 32'h01010101);
        corner(14'h0020, 32'h0000ffff, 32'h00010001);
        corner(14'h0100, 32'h1234abcd, 32'h5678ef01);
        for (int i = 0; i < 14; i++)
            run(14'h0001 << i, 32'h7fff8001, 32'hc0ff80ff, 5'(i), 2'(i), 4'he, 4'h5, 1'b0);
        repeat (300)
            run(14'h0001 << $urandom_range(13, 0), $urandom(), $urandom(), 5'($urandom()), 2'($urandom()),
                4'($urandom()), 4'($urandom()), $urandom_range(7, 0) == 0);
        close_out();
    end
endmodule
`default_nettype wire
